// [rtl/idp_pkg.sv]
package idp_pkg;

  // Word indices of the parameter block
  localparam logic [7:0] W_DEF_HEADS   = 8'h03;
  localparam logic [7:0] W_DEF_SPT     = 8'h06;
  localparam logic [7:0] W_TOTAL_LO    = 8'h07;
  localparam logic [7:0] W_TOTAL_HI    = 8'h08;
  localparam logic [7:0] W_SERIAL_FIRST = 8'h0a;
  localparam logic [7:0] W_SERIAL_LAST = 8'h13;
  localparam logic [7:0] W_FW_FIRST    = 8'h17;
  localparam logic [7:0] W_FW_LAST     = 8'h1a;
  localparam logic [7:0] W_MODEL_FIRST = 8'h1b;
  localparam logic [7:0] W_MODEL_LAST  = 8'h2e;
  localparam logic [7:0] W_MULT_MAX    = 8'h2f;
  localparam logic [7:0] W_CAPS_PRI    = 8'h31;
  localparam logic [7:0] W_CAPS_SEC    = 8'h32;
  localparam logic [7:0] W_LEGACY_PIO  = 8'h33;
  localparam logic [7:0] W_VALIDITY    = 8'h35;
  localparam logic [7:0] W_CUR_CYL     = 8'h36;
  localparam logic [7:0] W_CUR_HEADS   = 8'h37;
  localparam logic [7:0] W_CUR_SPT     = 8'h38;
  localparam logic [7:0] W_CUR_CAP_LO  = 8'h39;
  localparam logic [7:0] W_CUR_CAP_HI  = 8'h3a;
  localparam logic [7:0] W_MULT_SET    = 8'h3b;
  localparam logic [7:0] W_LBA_LO      = 8'h3c;
  localparam logic [7:0] W_LBA_HI      = 8'h3d;
  localparam logic [7:0] W_MDMA        = 8'h3f;
  localparam logic [7:0] W_ADV_PIO     = 8'h40;
  localparam logic [7:0] W_MDMA_MIN    = 8'h41;
  localparam logic [7:0] W_MDMA_REC    = 8'h42;
  localparam logic [7:0] W_PIO_NOFLOW  = 8'h43;
  localparam logic [7:0] W_PIO_FLOW    = 8'h44;
  localparam logic [7:0] W_CARD_SPEC   = 8'h45;
  localparam logic [7:0] W_QUEUE_DEPTH = 8'h4b;
  localparam logic [7:0] W_LINK_CAPS   = 8'h4c;
  localparam logic [7:0] W_UDMA        = 8'h58;
  localparam logic [7:0] W_LAST        = 8'hff;

  // String sizes in characters
  localparam int SERIAL_CHARS = 20;
  localparam int MODEL_CHARS  = 40;
  localparam logic [7:0] PAD_CHAR = 8'h20;

  // Fixed field contents
  localparam logic [15:0] CAPS_PRI_BASE = 16'h0300;
  localparam int          CAPS_IORDY_BIT = 11;
  localparam int          CAPS_IORDY_DIS_BIT = 10;
  localparam logic [15:0] CAPS_SEC_VAL  = 16'h0001;
  localparam logic [15:0] LEGACY_PIO_VAL = 16'h0200;
  localparam logic [15:0] VALIDITY_VAL  = 16'h0007;
  localparam logic [15:0] MULT_SET_VALID = 16'h0100;
  localparam logic [7:0]  MDMA_SUPPORT  = 8'h07;
  localparam logic [15:0] ADV_PIO_VAL   = 16'h0003;
  localparam logic [15:0] CARD_SPEC_VAL = 16'h8000;
  localparam logic [6:0]  UDMA_SUPPORT  = 7'h7f;
  localparam logic [2:0]  MDMA_TOP_MODE = 3'h2;
  localparam logic [2:0]  UDMA_TOP_MODE = 3'h6;

  // Cycle times in ns
  localparam logic [15:0] MDMA_MIN_NS   = 16'h0078;
  localparam logic [15:0] MDMA_REC_NS   = 16'h0078;
  localparam logic [15:0] PIO_NOFLOW_NS = 16'h0078;
  localparam logic [15:0] PIO_FLOW_NS   = 16'h0078;

  // Queue depth and link capability bits
  localparam logic [5:0] NCQ_DEPTH      = 6'h20;
  localparam int LINK_PHY_EVT_BIT = 10;
  localparam int LINK_HIPM_BIT    = 9;
  localparam int LINK_NCQ_BIT     = 8;
  localparam int LINK_GEN2_BIT    = 2;
  localparam int LINK_GEN1_BIT    = 1;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LOAD = 3'b010,
    ST_SEND = 3'b100
  } idp_state_t;

endpackage : idp_pkg

// [rtl/idp_identify.sv]
`timescale 1ns/10ps
module idp_identify
  import idp_pkg::*;
#(
  parameter bit IORDY_SUPPORTED = 1'b1,
  parameter bit IORDY_DISABLE   = 1'b1,
  parameter bit MDMA_CYC_SUPPORTED = 1'b1,
  parameter bit PIO_CYC_SUPPORTED  = 1'b1,
  parameter bit LINK_PHY_EVT = 1'b0,
  parameter bit LINK_HIPM    = 1'b1,
  parameter bit LINK_NCQ     = 1'b1,
  parameter bit LINK_GEN2    = 1'b1,
  parameter bit LINK_GEN1    = 1'b1
)(
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst,
  // Command
  input  wire logic         identify_start,
  output logic              identify_busy,
  output logic              identify_done,
  // Word stream
  output logic              word_valid,
  input  wire logic         word_ready,
  output logic [15:0]       word_data,
  output logic [7:0]        word_index,
  // Geometry and capacity
  input  wire logic [15:0]  def_heads,
  input  wire logic [15:0]  def_sectors_per_track,
  input  wire logic [31:0]  sectors_per_drive,
  input  wire logic [15:0]  cur_cylinders,
  input  wire logic [15:0]  cur_heads,
  input  wire logic [15:0]  cur_sectors_per_track,
  input  wire logic [31:0]  lba_total_sectors,
  // Strings: model starts in the top byte, serial ends at byte len-1
  input  wire logic [159:0] serial_text,
  input  wire logic [4:0]   serial_len,
  input  wire logic [63:0]  firmware_text,
  input  wire logic [319:0] model_text,
  input  wire logic [5:0]   model_len,
  // Host-changeable settings
  input  wire logic [7:0]   mult_sector_max,
  input  wire logic         mult_sector_on,
  input  wire logic         sel_udma,
  input  wire logic         sel_mdma,
  input  wire logic [2:0]   sel_mode
);

  idp_state_t  state_r;
  logic [7:0]  idx_r;
  logic [15:0] word_data_r;
  logic        done_r;
  logic [15:0] word_val;
  logic [7:0]  serial_img [SERIAL_CHARS];
  logic [7:0]  model_img [MODEL_CHARS];
  logic [47:0] cap_full;
  logic [31:0] cur_cap;
  logic [7:0]  mdma_sel_bits;
  logic [6:0]  udma_sel_bits;
  logic [15:0] caps_pri;
  logic [15:0] link_caps;
  logic [15:0] mdma_min;
  logic [15:0] mdma_rec;
  logic [15:0] pio_noflow;
  logic [15:0] pio_flow;
  logic [7:0]  mdma_seen_r;

  // Character images after justification and padding
  genvar gp;
  generate
    for (gp = 0; gp < SERIAL_CHARS; gp++)
    begin : g_serial
      localparam int SHIFT = SERIAL_CHARS - gp;
      always_comb
      begin
        if (int'(serial_len) < SHIFT)
          serial_img[gp] = PAD_CHAR;
        else
          serial_img[gp] = serial_text[8*(int'(serial_len) - SHIFT) +: 8];
      end
    end
    for (gp = 0; gp < MODEL_CHARS; gp++)
    begin : g_model
      always_comb
      begin
        if (gp < int'(model_len))
          model_img[gp] = model_text[319 - 8*gp -: 8];
        else
          model_img[gp] = PAD_CHAR;
      end
    end
  endgenerate

  // Product is 48 bits; only the low 32 fit the field
  assign cap_full = 48'(cur_cylinders) * 48'(cur_heads) * 48'(cur_sectors_per_track);
  assign cur_cap  = cap_full[31:0];

  // UDMA takes precedence so two selections can never show
  always_comb
  begin
    mdma_sel_bits = 8'h00;
    udma_sel_bits = 7'h00;
    if (sel_udma && sel_mode <= UDMA_TOP_MODE)
      udma_sel_bits = 7'h01 << sel_mode;
    else if (sel_mdma && sel_mode <= MDMA_TOP_MODE)
      mdma_sel_bits = 8'h01 << sel_mode;
  end

  always_comb
  begin
    caps_pri = CAPS_PRI_BASE;
    caps_pri[CAPS_IORDY_BIT] = IORDY_SUPPORTED;
    caps_pri[CAPS_IORDY_DIS_BIT] = IORDY_DISABLE;
    link_caps = 16'h0000;
    link_caps[LINK_PHY_EVT_BIT] = LINK_PHY_EVT;
    link_caps[LINK_HIPM_BIT] = LINK_HIPM;
    link_caps[LINK_NCQ_BIT] = LINK_NCQ;
    link_caps[LINK_GEN2_BIT] = LINK_GEN2;
    link_caps[LINK_GEN1_BIT] = LINK_GEN1;
  end

  // Unsupported cycle fields read zero while word 53 bit 1 stays set
  assign mdma_min   = MDMA_CYC_SUPPORTED ? MDMA_MIN_NS : 16'h0000;
  assign mdma_rec   = MDMA_CYC_SUPPORTED ? MDMA_REC_NS : 16'h0000;
  assign pio_noflow = PIO_CYC_SUPPORTED ? PIO_NOFLOW_NS : 16'h0000;
  assign pio_flow   = PIO_CYC_SUPPORTED ? PIO_FLOW_NS : 16'h0000;

  // Word selected by the current index
  always_comb
  begin
    word_val = 16'h0000;
    case (idx_r)
      W_DEF_HEADS:   word_val = def_heads;
      W_DEF_SPT:     word_val = def_sectors_per_track;
      W_TOTAL_LO:    word_val = sectors_per_drive[15:0];
      W_TOTAL_HI:    word_val = sectors_per_drive[31:16];
      W_MULT_MAX:    word_val = {8'h00, mult_sector_max};
      W_CAPS_PRI:    word_val = caps_pri;
      W_CAPS_SEC:    word_val = CAPS_SEC_VAL;
      W_LEGACY_PIO:  word_val = LEGACY_PIO_VAL;
      W_VALIDITY:    word_val = VALIDITY_VAL;
      W_CUR_CYL:     word_val = cur_cylinders;
      W_CUR_HEADS:   word_val = cur_heads;
      W_CUR_SPT:     word_val = cur_sectors_per_track;
      W_CUR_CAP_LO:  word_val = cur_cap[15:0];
      W_CUR_CAP_HI:  word_val = cur_cap[31:16];
      W_MULT_SET:    word_val = MULT_SET_VALID | {15'h0000, mult_sector_on};
      W_LBA_LO:      word_val = lba_total_sectors[15:0];
      W_LBA_HI:      word_val = lba_total_sectors[31:16];
      W_MDMA:        word_val = {mdma_sel_bits, MDMA_SUPPORT};
      W_ADV_PIO:     word_val = ADV_PIO_VAL;
      W_MDMA_MIN:    word_val = mdma_min;
      W_MDMA_REC:    word_val = mdma_rec;
      W_PIO_NOFLOW:  word_val = pio_noflow;
      W_PIO_FLOW:    word_val = pio_flow;
      W_CARD_SPEC:   word_val = CARD_SPEC_VAL;
      W_QUEUE_DEPTH: word_val = {11'h000, 5'(NCQ_DEPTH - 6'h01)};
      W_LINK_CAPS:   word_val = link_caps;
      W_UDMA:        word_val = {1'b0, udma_sel_bits, 1'b0, UDMA_SUPPORT};
      default:
      begin
        if (idx_r >= W_SERIAL_FIRST && idx_r <= W_SERIAL_LAST)
          word_val = {serial_img[2*int'(idx_r - W_SERIAL_FIRST)],
                      serial_img[2*int'(idx_r - W_SERIAL_FIRST) + 1]};
        else if (idx_r >= W_FW_FIRST && idx_r <= W_FW_LAST)
          word_val = firmware_text[63 - 16*int'(idx_r - W_FW_FIRST) -: 16];
        else if (idx_r >= W_MODEL_FIRST && idx_r <= W_MODEL_LAST)
          word_val = {model_img[2*int'(idx_r - W_MODEL_FIRST)],
                      model_img[2*int'(idx_r - W_MODEL_FIRST) + 1]};
        else
          word_val = 16'h0000;
      end
    endcase
  end

  // Sequencer: one load cycle per word keeps the data output registered
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= ST_IDLE;
      idx_r   <= 8'h00;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (identify_start)
          begin
            state_r <= ST_LOAD;
            idx_r   <= 8'h00;
          end
        end
        ST_LOAD:
          state_r <= ST_SEND;
        ST_SEND:
        begin
          if (word_ready)
          begin
            if (idx_r == W_LAST)
              state_r <= ST_IDLE;
            else
            begin
              state_r <= ST_LOAD;
              idx_r   <= idx_r + 8'h01;
            end
          end
        end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      word_data_r <= 16'h0000;
    else if (state_r == ST_LOAD)
      word_data_r <= word_val;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      done_r <= 1'b0;
    else
      done_r <= (state_r == ST_SEND) && word_ready && (idx_r == W_LAST);
  end

  assign word_valid    = (state_r == ST_SEND);
  assign word_data     = word_data_r;
  assign word_index    = idx_r;
  assign identify_busy = (state_r != ST_IDLE);
  assign identify_done = done_r;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_validity_word: assert property (
    word_valid && word_index == W_VALIDITY |-> word_data == 16'h0007)
    else $error("word 53 value wrong");

  a_caps_bits: assert property (
    word_valid && word_index == W_CAPS_PRI |-> !word_data[13] && word_data[9:8] == 2'b11)
    else $error("word 49 capability bits wrong");

  a_legacy_pio: assert property (
    word_valid && word_index == W_LEGACY_PIO |-> word_data[15:8] == 8'h02)
    else $error("word 51 high byte wrong");

  a_mult_setting: assert property (
    word_valid && word_index == W_MULT_SET |-> word_data[15:8] == 8'h01 && word_data[7:1] == 7'h00)
    else $error("word 59 layout wrong");

  a_mdma_onehot: assert property (
    word_valid && word_index == W_MDMA |-> $onehot0(word_data[15:8]) && word_data[15:11] == 5'h00)
    else $error("word 63 selection not one-hot");

  a_dma_exclusive: assert property (
    !(mdma_sel_bits != 8'h00 && udma_sel_bits != 7'h00))
    else $error("UDMA and MDMA selected together");

  a_cap_product: assert property (
    state_r == ST_LOAD && idx_r == W_CUR_CAP_HI |=> word_data == 16'(cap_full >> 16))
    else $error("current capacity high word wrong");

  a_serial_pad: assert property (
    word_valid && word_index == W_SERIAL_FIRST && serial_len < 5'd19 |-> word_data == 16'h2020)
    else $error("serial leading pad missing");

  a_cycle_order: assert property (
    word_valid && word_index == W_MDMA_REC |-> word_data >= mdma_min)
    else $error("recommended cycle below minimum");

  a_word_order: assert property (
    word_valid && word_ready && word_index != W_LAST
      |-> ##2 (word_valid && word_index == $past(word_index, 2) + 8'h01))
    else $error("words not delivered in index order");

  a_block_end: assert property (
    word_valid && word_ready && word_index == W_LAST |=> identify_done && !identify_busy)
    else $error("block did not end after word 255");

  // Word 63 selection kept, so word 88 is checked on the outputs, not the decode
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      mdma_seen_r <= 8'h00;
    else if (word_valid && word_index == W_MDMA)
      mdma_seen_r <= word_data[15:8];
  end

  a_dma_out_exclusive: assert property (
    word_valid && word_index == W_UDMA |-> mdma_seen_r == 8'h00 || word_data[14:8] == 7'h00)
    else $error("word 63 and word 88 both show a selection");

  a_total_low: assert property (
    word_valid && word_index == W_TOTAL_LO |-> word_data == sectors_per_drive[15:0])
    else $error("word 7 sector count wrong");

  a_total_high: assert property (
    word_valid && word_index == W_TOTAL_HI |-> word_data == sectors_per_drive[31:16])
    else $error("word 8 sector count wrong");

  a_mult_max: assert property (
    word_valid && word_index == W_MULT_MAX |-> word_data == {8'h00, mult_sector_max})
    else $error("word 47 multiple count wrong");

  a_caps_timer: assert property (
    word_valid && word_index == W_CAPS_SEC |-> word_data[0])
    else $error("word 50 bit 0 clear");

  a_mdma_support: assert property (
    word_valid && word_index == W_MDMA |-> word_data[7:0] == 8'h07)
    else $error("word 63 support byte wrong");

  a_adv_pio: assert property (
    word_valid && word_index == W_ADV_PIO |-> word_data[7:0] == 8'h03)
    else $error("word 64 advanced modes wrong");

  a_pio_order: assert property (
    word_valid && word_index == W_PIO_NOFLOW |-> word_data >= pio_flow)
    else $error("word 67 below word 68");

  a_card_spec: assert property (
    word_valid && word_index == W_CARD_SPEC |-> word_data[15])
    else $error("word 69 bit 15 clear");

  a_queue_depth: assert property (
    word_valid && word_index == W_QUEUE_DEPTH |-> word_data == 16'h001f)
    else $error("word 75 queue depth wrong");

  a_link_caps: assert property (
    word_valid && word_index == W_LINK_CAPS |-> !word_data[0] && word_data[15:11] == 5'h00)
    else $error("word 76 reserved bits set");

  a_model_pad: assert property (
    word_valid && word_index == W_MODEL_LAST && model_len < 6'd39 |-> word_data == 16'h2020)
    else $error("model trailing pad missing");

  a_reset_quiet: assert property (
    $fell(rst) |-> !word_valid && !identify_busy && !identify_done)
    else $error("outputs active after reset");

  a_done_pulse: assert property (
    identify_done |=> !identify_done)
    else $error("done longer than one cycle");

  a_valid_gap: assert property (
    word_valid && word_ready |=> !word_valid)
    else $error("no idle cycle between words");

  a_word_stands: assert property (
    word_valid && !word_ready |=> word_valid && $stable(word_data) && $stable(word_index))
    else $error("word changed before it was taken");

endmodule : idp_identify

// [test/idp_host_model.sv]
`timescale 1ns/10ps
module idp_host_model (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Word stream
  input  wire logic        word_valid,
  output logic             word_ready,
  input  wire logic [15:0] word_data,
  input  wire logic [7:0]  word_index,
  // Pacing and capture
  input  wire logic        slow,
  input  wire logic        clear,
  output logic [15:0]      got [256],
  output logic [15:0]      got_cnt,
  output logic             order_err
);
  logic [1:0] pace_r;

  // Slow mode stalls three cycles in four to stretch every word
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pace_r     <= 2'h0;
      word_ready <= 1'b0;
      got_cnt    <= 16'h0000;
      order_err  <= 1'b0;
    end
    else
    begin
      pace_r     <= pace_r + 2'h1;
      word_ready <= !slow || (pace_r == 2'h2);
      if (clear)
      begin
        got_cnt   <= 16'h0000;
        order_err <= 1'b0;
      end
      else if (word_valid && word_ready)
      begin
        got[word_index] <= word_data;
        if (word_index != got_cnt[7:0])
          order_err <= 1'b1;
        got_cnt <= got_cnt + 16'h0001;
      end
    end
  end
endmodule : idp_host_model

// [test/idp_identify_tb_top.sv]
`timescale 1ns/10ps
module idp_identify_tb_top;
  import idp_pkg::*;
  logic         core_clk, rst, identify_start, identify_busy, identify_done;
  logic         word_valid, word_ready, slow, clear, order_err;
  logic         mult_sector_on, sel_udma, sel_mdma;
  logic [2:0]   sel_mode;
  logic [4:0]   serial_len;
  logic [5:0]   model_len;
  logic [7:0]   word_index, mult_sector_max;
  logic [15:0]  word_data, def_heads, def_spt, cur_cyl, cur_heads, cur_spt, got_cnt;
  logic [15:0]  got [256];
  logic [31:0]  sectors_per_drive, lba_total_sectors;
  logic [63:0]  firmware_text;
  logic [159:0] serial_text;
  logic [319:0] model_text;
  int           errors;
  int           checked;

  idp_identify dut_u (.core_clk(core_clk), .rst(rst), .identify_start(identify_start),
    .identify_busy(identify_busy), .identify_done(identify_done), .word_valid(word_valid),
    .word_ready(word_ready), .word_data(word_data), .word_index(word_index),
    .def_heads(def_heads), .def_sectors_per_track(def_spt),
    .sectors_per_drive(sectors_per_drive), .cur_cylinders(cur_cyl), .cur_heads(cur_heads),
    .cur_sectors_per_track(cur_spt), .lba_total_sectors(lba_total_sectors),
    .serial_text(serial_text), .serial_len(serial_len), .firmware_text(firmware_text),
    .model_text(model_text), .model_len(model_len), .mult_sector_max(mult_sector_max),
    .mult_sector_on(mult_sector_on), .sel_udma(sel_udma), .sel_mdma(sel_mdma),
    .sel_mode(sel_mode));

  idp_host_model host_u (.core_clk(core_clk), .rst(rst), .word_valid(word_valid),
    .word_ready(word_ready), .word_data(word_data), .word_index(word_index), .slow(slow),
    .clear(clear), .got(got), .got_cnt(got_cnt), .order_err(order_err));

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  function automatic logic [7:0] ser_ch(input int p);
    ser_ch = (p < 20 - int'(serial_len)) ? 8'h20 : serial_text[8*(p + int'(serial_len) - 20) +: 8];
  endfunction : ser_ch

  function automatic logic [7:0] mod_ch(input int p);
    mod_ch = (p < model_len) ? model_text[319-8*p -: 8] : 8'h20;
  endfunction : mod_ch

  function automatic logic [15:0] exp_word(input int w);
    logic [47:0] prod;
    logic [7:0]  mdma_sel;
    logic [6:0]  udma_sel;
    prod     = {32'h0, cur_cyl} * {32'h0, cur_heads} * {32'h0, cur_spt};
    udma_sel = (sel_udma && sel_mode <= 3'h6) ? (7'h01 << sel_mode) : 7'h00;
    mdma_sel = (sel_mdma && !sel_udma && sel_mode <= 3'h2) ? (8'h01 << sel_mode) : 8'h00;
    exp_word = 16'h0000;
    if (w >= 10 && w <= 19)
      exp_word = {ser_ch(2*(w-10)), ser_ch(2*(w-10)+1)};
    else if (w >= 27 && w <= 46)
      exp_word = {mod_ch(2*(w-27)), mod_ch(2*(w-27)+1)};
    else if (w >= 23 && w <= 26)
      exp_word = firmware_text[63-16*(w-23) -: 16];
    else
      case (w)
        3: exp_word = def_heads;
        6: exp_word = def_spt;
        7: exp_word = sectors_per_drive[15:0];
        8: exp_word = sectors_per_drive[31:16];
        47: exp_word = {8'h00, mult_sector_max};
        49: exp_word = 16'h0f00;
        50: exp_word = 16'h0001;
        51: exp_word = 16'h0200;
        53: exp_word = 16'h0007;
        54: exp_word = cur_cyl;
        55: exp_word = cur_heads;
        56: exp_word = cur_spt;
        57: exp_word = prod[15:0];
        58: exp_word = prod[31:16];
        59: exp_word = {8'h01, 7'h00, mult_sector_on};
        60: exp_word = lba_total_sectors[15:0];
        61: exp_word = lba_total_sectors[31:16];
        63: exp_word = {mdma_sel, 8'h07};
        64: exp_word = 16'h0003;
        65, 66: exp_word = 16'h0078;
        67, 68: exp_word = 16'h0078;
        69: exp_word = 16'h8000;
        75: exp_word = 16'h001f;
        76: exp_word = 16'h0306;
        88: exp_word = {1'b0, udma_sel, 1'b0, 7'h7f};
        default: exp_word = 16'h0000;
      endcase
  endfunction : exp_word

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up

  // A second start while busy must not restart the block
  task automatic run_block(input logic s);
    int n;
    slow = s;
    clear = 1'b1;
    @(negedge core_clk);
    clear = 1'b0;
    identify_start = 1'b1;
    @(negedge core_clk);
    chk({15'h0, identify_busy}, 16'h0001);
    @(negedge core_clk);
    identify_start = 1'b0;
    n = 0;
    while (identify_done !== 1'b1 && n < 5000)
    begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 5000)
    begin
      errors++;
      wrap_up();
    end
    chk({15'h0, identify_busy}, 16'h0000);
    chk(got_cnt, 16'h0100);
    chk({15'h0, order_err}, 16'h0000);
    @(negedge core_clk);
    chk({15'h0, identify_done}, 16'h0000);
    for (int w = 0; w < 256; w++)
      chk(got[w], exp_word(w));
    chk({15'h0, ($countones({got[63][15:8], got[88][14:8]}) > 1)}, 16'h0000);
  endtask : run_block

  initial
  begin
    errors = 0;
    checked = 0;
    rst = 1'b1;
    identify_start = 1'b0;
    slow = 1'b0;
    clear = 1'b0;
    def_heads = 16'h0010;
    def_spt = 16'h003f;
    sectors_per_drive = 32'h01e8_4800;
    cur_cyl = 16'h3a2c;
    cur_heads = 16'h000f;
    cur_spt = 16'h003f;
    lba_total_sectors = 32'h00ee_1234;
    firmware_text = 64'h312e_3032_2020_2041;
    for (int i = 0; i < 20; i++)
      serial_text[8*i +: 8] = 8'h30 + i[7:0];
    for (int i = 0; i < 40; i++)
      model_text[8*i +: 8] = 8'h41 + i[7:0];
    serial_len = 5'd7;
    model_len = 6'd13;
    mult_sector_max = 8'h01;
    mult_sector_on = 1'b0;
    sel_udma = 1'b0;
    sel_mdma = 1'b1;
    sel_mode = 3'h0;
    repeat (5) @(negedge core_clk);
    rst = 1'b0;
    // Every multiword mode plus one out of range
    for (int m = 0; m < 4; m++)
    begin
      sel_mode = m[2:0];
      run_block(m[0]);
    end
    // Full-length strings, ultra selection overrides multiword
    sel_udma = 1'b1;
    serial_len = 5'd20;
    model_len = 6'd40;
    mult_sector_on = 1'b1;
    mult_sector_max = 8'hff;
    for (int m = 0; m < 8; m++)
    begin
      sel_mode = m[2:0];
      run_block(m[1]);
    end
    // Empty strings; reset in mid block, then a clean block
    serial_len = 5'd0;
    model_len = 6'd0;
    sel_udma = 1'b0;
    identify_start = 1'b1;
    @(negedge core_clk);
    identify_start = 1'b0;
    repeat (20) @(negedge core_clk);
    rst = 1'b1;
    @(negedge core_clk);
    chk({14'h0, word_valid, identify_busy}, 16'h0000);
    chk({identify_done, 7'h0, word_index}, 16'h0000);
    chk(word_data, 16'h0000);
    rst = 1'b0;
    run_block(1'b1);
    wrap_up();
  end
endmodule : idp_identify_tb_top
